// ===== inc/wut_pkg.sv
// constants, types and field layout of the wake-up timer
//=====================================================================
//=====================================================================
package wut_pkg;
    // register byte addresses on the apb bus
    localparam logic [31:0] ADDR_RELOAD = 32'hFFFF0340;
    localparam logic [31:0] ADDR_COUNT  = 32'hFFFF0344;
    localparam logic [31:0] ADDR_CTRL   = 32'hFFFF0348;
    localparam logic [31:0] ADDR_CLEAR  = 32'hFFFF034C;
    localparam logic [31:0] ADDR_STATUS = 32'hFFFF0350;
    localparam logic [31:0] ADDR_MASK   = 32'hFFFF0354;

    // reset values
    localparam logic [31:0] RST_RELOAD = 32'h00000000;
    localparam logic [31:0] RST_COUNT  = 32'h0FFFFFFF;
    localparam logic [10:0] RST_CTRL   = 11'h000;
    localparam logic        RST_MASK   = 1'h1;

    // control field positions (bits 31..11 reserved, read zero)
    localparam int CTRL_W      = 11;
    localparam int BIT_CLKSEL  = 9;
    localparam int BIT_DIR     = 8;
    localparam int BIT_EN      = 7;
    localparam int BIT_MOD     = 6;
    localparam int BIT_FMT     = 4;
    localparam int BIT_SCALE   = 0;

    // clock source codes
    typedef enum logic [1:0] {
        WUT_SRC_OSC  = 2'h0,
        WUT_SRC_DIV  = 2'h1,
        WUT_SRC_XTAL = 2'h2,
        WUT_SRC_FAST = 2'h3
    } wut_src_e;

    // count format codes
    typedef enum logic [1:0] {
        WUT_FMT_BIN    = 2'h0,
        WUT_FMT_RSV    = 2'h1,
        WUT_FMT_HMS23  = 2'h2,
        WUT_FMT_HMS255 = 2'h3
    } wut_fmt_e;

    // prescaler codes and their divide shifts
    localparam logic [3:0] SCALE_16    = 4'h4;
    localparam logic [3:0] SCALE_256   = 4'h8;
    localparam logic [3:0] SCALE_32768 = 4'hF;
    localparam logic [3:0] SHIFT_16    = 4'h4;
    localparam logic [3:0] SHIFT_256   = 4'h8;
    localparam logic [3:0] SHIFT_32768 = 4'hF;

    // hms layout: one byte per field, hundredths lowest
    localparam logic [7:0] HUN_MAX   = 8'h63;
    localparam logic [7:0] SEC_MAX   = 8'h3B;
    localparam logic [7:0] MIN_MAX   = 8'h3B;
    localparam logic [7:0] HR23_MAX  = 8'h17;
    localparam logic [7:0] HR255_MAX = 8'hFF;
endpackage

// ===== rtl/wut_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module wut_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    //=================================================================
    // synchroniser stages
    logic [WIDTH-1:0] meta; // first stage, read only by second

    // two stages, nothing but the second one looks at the first one
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule // wut_sync

// ===== rtl/wut_prescale.sv
// prescaler: one tick every 2**shift source edges
`timescale 1ns/1ns
module wut_prescale (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       edge_i,
    input  wire logic [3:0] shift_i,
    output logic            tick_o
);
    //=================================================================
    // edge counter
    logic [14:0] cnt;      // free count of source edges
    logic [14:0] next_cnt; // next edge count
    logic [14:0] mask;     // low bits that must be all ones

    // tick on the edge that completes a full group
    always_comb begin
        mask     = ~(15'h7FFF << shift_i);
        tick_o   = edge_i && ((cnt & mask) == mask);
        next_cnt = edge_i ? cnt + 15'h0001 : cnt;
    end

    // register the count
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 15'h0000;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule // wut_prescale

// ===== rtl/wut_top.sv
// wake-up timer with apb registers and interrupt
`timescale 1ns/1ns
module wut_top
    import wut_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        osc32k_i,
    input  wire logic        core_divider_i,
    input  wire logic        crystal_input_i,
    input  wire logic        clk_10m_i,
    output logic             irq_o
);
    //=================================================================
    // apb decode
    logic        setup;    // first cycle of a transfer
    logic        access;   // access cycle, always ready
    logic        wr;       // write taken this edge
    logic        hit;      // address maps to a register
    logic        clr_wr;   // write to interrupt_clear
    logic        st_w1c;   // write one to status bit

    // decode is combinational; zero wait states
    always_comb begin
        setup  = psel_i && !penable_i;
        access = psel_i && penable_i;
        wr     = access && pwrite_i;
        hit    = (paddr_i >= ADDR_RELOAD) && (paddr_i <= ADDR_MASK) &&
                 (paddr_i[1:0] == 2'h0);
        // any data value clears, width unused
        clr_wr = wr && (paddr_i == ADDR_CLEAR);
        st_w1c = wr && (paddr_i == ADDR_STATUS) && pwdata_i[0];
    end

    // answer at once; unmapped addresses flag an error
    assign pready_o  = 1'h1;
    assign pslverr_o = access && !hit;

    //=================================================================
    // software registers
    logic [31:0]       reload;      // reload_value
    logic [31:0]       next_reload; // next reload_value
    logic [CTRL_W-1:0] ctrl;        // timer_control, used bits
    logic [CTRL_W-1:0] next_ctrl;   // next timer_control
    logic              mask;        // interrupt mask
    logic              next_mask;   // next mask

    // writes land at the access edge
    always_comb begin
        next_reload = reload;
        next_ctrl   = ctrl;
        next_mask   = mask;
        if (wr && paddr_i == ADDR_RELOAD) begin
            next_reload = pwdata_i;
        end
        if (wr && paddr_i == ADDR_CTRL) begin
            next_ctrl = pwdata_i[CTRL_W-1:0];
        end
        if (wr && paddr_i == ADDR_MASK) begin
            next_mask = pwdata_i[0];
        end
    end

    // register file state
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reload <= RST_RELOAD;
            ctrl   <= RST_CTRL;
            mask   <= RST_MASK;
        end else begin
            reload <= next_reload;
            ctrl   <= next_ctrl;
            mask   <= next_mask;
        end
    end

    //=================================================================
    // control fields
    wut_src_e   src;      // clock source select
    wut_fmt_e   fmt;      // count format
    logic [3:0] scale;    // prescale select code
    logic       dir_up;   // count direction
    logic       en;       // counter enable
    logic       periodic; // periodic select

    // unpack the control word
    always_comb begin
        src      = wut_src_e'(ctrl[BIT_CLKSEL +: 2]);
        fmt      = wut_fmt_e'(ctrl[BIT_FMT +: 2]);
        scale    = ctrl[BIT_SCALE +: 4];
        dir_up   = ctrl[BIT_DIR];
        en       = ctrl[BIT_EN];
        periodic = ctrl[BIT_MOD];
    end

    //=================================================================
    // source clocks: synchronise, then detect rising edges
    logic [3:0] pins_s; // synchronised source levels
    logic [3:0] pins_d; // one cycle older levels
    logic [3:0] rise;   // rising edge per source
    logic       src_edge; // edge of the selected source

    // sources are slow against mclk, so sampling is enough
    wut_sync #(
        .WIDTH (4)
    ) u_sync (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .async_i ({clk_10m_i, crystal_input_i,
                   core_divider_i, osc32k_i}),
        .sync_o  (pins_s)
    );

    // delay stage for edge detection
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_d <= 4'h0;
        end else begin
            pins_d <= pins_s;
        end
    end

    // pick the source by its code
    always_comb begin
        rise = pins_s & ~pins_d;
        case (src)
            WUT_SRC_OSC:  src_edge = rise[0];
            WUT_SRC_DIV:  src_edge = rise[1];
            WUT_SRC_XTAL: src_edge = rise[2];
            WUT_SRC_FAST: src_edge = rise[3];
            default:      src_edge = 1'h0;
        endcase
    end

    //=================================================================
    // prescaler
    logic [3:0] shift; // log2 of the divide ratio
    logic       tick;  // one count step due

    // undefined codes fall back to divide by one
    always_comb begin
        case (scale)
            SCALE_16:    shift = SHIFT_16;
            SCALE_256:   shift = SHIFT_256;
            SCALE_32768: shift = SHIFT_32768;
            default:     shift = 4'h0;
        endcase
    end

    // divider shared by every source
    wut_prescale u_prescale (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .edge_i  (src_edge),
        .shift_i (shift),
        .tick_o  (tick)
    );

    //=================================================================
    // time-of-day step, one field per byte with carry or borrow
    function automatic logic [31:0] hms_step(
        input logic [31:0] v,
        input logic        up,
        input logic [7:0]  hmax
    );
        logic [7:0] f   [4];
        logic [7:0] lim [4];
        logic       carry;
        lim[0] = HUN_MAX;
        lim[1] = SEC_MAX;
        lim[2] = MIN_MAX;
        lim[3] = hmax;
        carry  = 1'h1;
        for (int i = 0; i < 4; i++) begin
            f[i] = v[i*8 +: 8];
            if (carry && up) begin
                if (f[i] >= lim[i]) begin
                    f[i] = 8'h00;
                end else begin
                    f[i]  = f[i] + 8'h01;
                    carry = 1'h0;
                end
            end else if (carry) begin
                if (f[i] == 8'h00) begin
                    f[i] = lim[i];
                end else begin
                    f[i]  = f[i] - 8'h01;
                    carry = 1'h0;
                end
            end
        end
        return {f[3], f[2], f[1], f[0]};
    endfunction

    //=================================================================
    // counter
    logic [31:0] count;      // current_count
    logic [31:0] next_count; // next current_count
    logic        hms;        // time-of-day format active
    logic [7:0]  hmax;       // top hour of that format
    logic [31:0] top;        // terminal value when counting up
    logic        term;       // at terminal count this step
    logic        timeout;    // terminal reached on a tick

    // reserved format 01 behaves as binary
    always_comb begin
        hms  = (fmt == WUT_FMT_HMS23) || (fmt == WUT_FMT_HMS255);
        hmax = (fmt == WUT_FMT_HMS23) ? HR23_MAX : HR255_MAX;
        top  = hms ? {hmax, MIN_MAX, SEC_MAX, HUN_MAX} : 32'hFFFFFFFF;
        term = dir_up ? (count == top) : (count == 32'h00000000);
    end

    // clear write outranks a tick in the same cycle; no core
    // clock gating reaches this logic, so it counts on sleep
    always_comb begin
        next_count = count;
        timeout    = 1'h0;
        if (clr_wr) begin
            next_count = reload;
        end else if (en && tick) begin
            timeout = term;
            if (term && periodic) begin
                next_count = reload;
            end else if (hms) begin
                next_count = hms_step(count, dir_up, hmax);
            end else if (dir_up) begin
                next_count = count + 32'h00000001;
            end else begin
                next_count = count - 32'h00000001;
            end
        end
    end

    // count register; writes to its address are dropped
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= RST_COUNT;
        end else begin
            count <= next_count;
        end
    end

    //=================================================================
    // pending flag and interrupt
    logic pending;      // sticky timeout flag
    logic next_pending; // next flag

    // a timeout in a status write-one cycle still sets the flag; a clear write blocks the timeout
    always_comb begin
        next_pending = timeout ||
                       (pending && !(clr_wr || st_w1c));
    end

    // flag register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pending <= 1'h0;
        end else begin
            pending <= next_pending;
        end
    end

    assign irq_o = pending && mask;

    //=================================================================
    // read data, captured in setup so it comes from a flip-flop
    logic [31:0] rdata;      // value to capture
    logic [31:0] next_rdata; // next prdata

    // interrupt_clear and unmapped addresses read zero
    always_comb begin
        case (paddr_i)
            ADDR_RELOAD: rdata = reload;
            ADDR_COUNT:  rdata = count;
            ADDR_CTRL:   rdata = {21'h000000, ctrl};
            ADDR_STATUS: rdata = {31'h00000000, pending};
            ADDR_MASK:   rdata = {31'h00000000, mask};
            default:     rdata = 32'h00000000;
        endcase
        next_rdata = (setup && !pwrite_i) ? rdata : prdata_o;
    end

    // read data register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h00000000;
        end else begin
            prdata_o <= next_rdata;
        end
    end

    //=================================================================
    // checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    property p_clr_reload;
        clr_wr |=> count == $past(reload);
    endproperty
    a_clr_reload: assert property (p_clr_reload)
        else $error("clear write did not reload counter");
    property p_clr_irq;
        clr_wr && !timeout |=> !pending && !irq_o;
    endproperty
    a_clr_irq: assert property (p_clr_irq)
        else $error("clear write left interrupt pending");
    property p_hold;
        !en && !clr_wr |=> $stable(count);
    endproperty
    a_hold: assert property (p_hold)
        else $error("disabled counter moved");
    property p_down;
        en && tick && !hms && !dir_up && !clr_wr
            && count != 32'h00000000
            |=> count == $past(count) - 32'h00000001;
    endproperty
    a_down: assert property (p_down)
        else $error("down count step wrong");
    property p_up;
        en && tick && !hms && dir_up && !clr_wr && !term
            |=> count == $past(count) + 32'h00000001;
    endproperty
    a_up: assert property (p_up)
        else $error("up count step wrong");
    property p_periodic;
        en && tick && periodic && term && !clr_wr
            |=> count == $past(reload);
    endproperty
    a_periodic: assert property (p_periodic)
        else $error("periodic reload missed");
    property p_wrap;
        en && tick && !periodic && !hms && !dir_up && !clr_wr
            && count == 32'h00000000 |=> count == 32'hFFFFFFFF;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("free-running wrap wrong");
    property p_hms23;
        en && tick && !periodic && !clr_wr && !dir_up
            && fmt == WUT_FMT_HMS23 && count == 32'h00000000
            |=> count == 32'h173B3B63;
    endproperty
    a_hms23: assert property (p_hms23)
        else $error("hms 23-hour wrap wrong");
    property p_sticky;
        timeout ##1 (!clr_wr && !st_w1c) [*2] |-> pending;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("pending flag dropped without clear");
    property p_irq;
        timeout && mask && !(wr && paddr_i == ADDR_MASK) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("timeout gave no interrupt");
    property p_ro;
        wr && paddr_i == ADDR_COUNT && !en |=> $stable(count);
    endproperty
    a_ro: assert property (p_ro)
        else $error("value register took a write");
endmodule // wut_top

// ===== sim/wut_top_bench.sv
// self-checking bench for the wake-up timer
`timescale 1ns/1ns
module wut_top_bench;
    import wut_pkg::*;
    //==================================================================
    // bench signals
    logic        mclk         = 1'b0;         // 125 MHz system clock
    logic        rstn         = 1'b0;         // async reset, low active
    logic        psel         = 1'b0;         // apb select
    logic        penab        = 1'b0;         // apb enable
    logic        pwr          = 1'b0;         // apb direction
    logic [31:0] paddr        = 32'h00000000; // apb address
    logic [31:0] pwdata       = 32'h00000000; // apb write data
    logic [3:0]  pins         = 4'h0;         // source levels, index = code
    logic [31:0] prdata;                      // read data
    logic        pready;                      // slave ready
    logic        pslverr;                     // slave error
    logic        irq;                         // interrupt line
    logic [31:0] rd;                          // data of last transfer
    logic        er;                          // error of last transfer
    logic [31:0] r;                           // random reload value
    int          n;                           // random pulse count
    int          errors       = 0;            // mismatches seen
    int          total_checks = 0;            // comparisons made
    int          cycles       = 0;            // clocks since start
    logic [3:0]  sc [4] = '{4'h0, 4'h4, 4'h8, 4'hF}; // prescale codes
    int          sh [4] = '{0, 4, 8, 15};     // their divide shifts
    int          ed [4] = '{3, 32, 256, 16};  // edges sent per code

    //==================================================================
    // design and clock
    wut_top i_dut (
        .mclk_i          (mclk),
        .rstn_i          (rstn),
        .psel_i          (psel),
        .penable_i       (penab),
        .pwrite_i        (pwr),
        .paddr_i         (paddr),
        .pwdata_i        (pwdata),
        .prdata_o        (prdata),
        .pready_o        (pready),
        .pslverr_o       (pslverr),
        .osc32k_i        (pins[0]),
        .core_divider_i  (pins[1]),
        .crystal_input_i (pins[2]),
        .clk_10m_i       (pins[3]),
        .irq_o           (irq)
    );

    // 8 ns period
    always #4 mclk = ~mclk;

    // hang guard: the whole run needs well under this many clocks
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            report_and_stop();
        end
    end

    //==================================================================
    // helpers
    // compare one value, count and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: seen %h want %h", $time, msg, seen, exp);
        end
    endtask

    // one apb transfer; holds everything until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penab <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penab <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp,
                       input string msg);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp, msg);
    endtask

    // irq is looked at mid-cycle, after register updates have landed
    task automatic chk_irq(input logic exp);
        @(negedge mclk);
        chk({31'h0, irq}, {31'h0, exp}, "irq level");
        @(posedge mclk);
    endtask

    // n rising edges on the chosen source; the other pins get twice as
    // many so a wrong source select shows as a wrong count
    task automatic pulse(input int s, input int cnt);
        logic [3:0] sel;
        sel = 4'h1 << s;
        repeat (cnt) begin
            pins <= 4'hF;
            repeat (2) @(posedge mclk);
            pins <= sel;
            repeat (2) @(posedge mclk);
            pins <= 4'hF;
            repeat (2) @(posedge mclk);
            pins <= 4'h0;
            repeat (2) @(posedge mclk);
        end
        repeat (8) @(posedge mclk);
    endtask

    // control word: source, up, enable, periodic, format, prescale
    function automatic logic [31:0] cw(input logic [1:0] src,
        input logic up, input logic en, input logic per,
        input logic [1:0] fmt, input logic [3:0] scl);
        cw = {21'h0, src, up, en, per, fmt, scl};
    endfunction

    // binary count after cnt ticks, no wrap
    function automatic logic [31:0] nxt(input logic [31:0] v,
                                        input logic up, input int cnt);
        nxt = up ? v + 32'(cnt) : v - 32'(cnt);
    endfunction

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    //==================================================================
    // main sequence
    initial begin
        void'($urandom(32'hBD95));
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk_irq(1'b0);
        @(posedge mclk);
        rdc(ADDR_RELOAD, 32'h00000000, "reload reset");
        rdc(ADDR_COUNT, 32'h0FFFFFFF, "count reset");
        rdc(ADDR_CTRL, 32'h00000000, "control reset");
        rdc(ADDR_STATUS, 32'h00000000, "status reset");
        rdc(ADDR_MASK, 32'h00000001, "mask reset");
        // access kinds, unmapped place
        r = $urandom();
        wr(ADDR_RELOAD, r);
        rdc(ADDR_RELOAD, r, "reload rw");
        wr(ADDR_COUNT, ~r);
        rdc(ADDR_COUNT, 32'h0FFFFFFF, "count ignores write");
        rdc(ADDR_CLEAR, 32'h00000000, "clear reads zero");
        apb(1'b0, 32'hFFFF0358, 32'h00000000);
        chk({31'h0, er}, 32'h1, "unmapped error");
        r = $urandom() & 32'hFFFFFF7F;
        wr(ADDR_CTRL, r);
        rdc(ADDR_CTRL, {21'h0, r[10:0]}, "control rw");
        // clear write reloads, disabled counter holds
        r = $urandom();
        wr(ADDR_CTRL, 32'h00000000);
        wr(ADDR_RELOAD, r);
        wr(ADDR_CLEAR, $urandom());
        rdc(ADDR_COUNT, r, "clear reloads");
        pulse(0, 3);
        rdc(ADDR_COUNT, r, "disabled holds");
        // every source, odd codes count up
        for (int s = 0; s < 4; s++) begin
            r = ($urandom() & 32'h00FFFFFF) | 32'h40000000;
            n = 1 + ($urandom() % 6);
            wr(ADDR_RELOAD, r);
            wr(ADDR_CLEAR, 32'h00000000);
            wr(ADDR_CTRL, cw(2'(s), s[0], 1'b1, 1'b0, 2'h0, 4'h0));
            pulse(s, n);
            wr(ADDR_CTRL, 32'h00000000);
            rdc(ADDR_COUNT, nxt(r, s[0], n), "source count");
        end
        // prescale codes 0, 4, 8 and F; whole multiples of the division except F, which gets 16 edges and no tick
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_RELOAD, 32'h00001000);
            wr(ADDR_CLEAR, 32'h00000000);
            wr(ADDR_CTRL, cw(2'h3, 1'b0, 1'b1, 1'b0, 2'h0, sc[i]));
            pulse(3, ed[i]);
            wr(ADDR_CTRL, 32'h00000000);
            rdc(ADDR_COUNT, nxt(32'h1000, 1'b0, ed[i] >> sh[i]),
                "prescale");
        end
        // periodic down timeout, interrupt mask and clears
        wr(ADDR_RELOAD, 32'h00000003);
        wr(ADDR_CLEAR, 32'h00000000);
        wr(ADDR_CTRL, cw(2'h3, 1'b0, 1'b1, 1'b1, 2'h0, 4'h0));
        pulse(3, 4);
        rdc(ADDR_COUNT, 32'h00000003, "periodic reload");
        rdc(ADDR_STATUS, 32'h00000001, "pending set");
        chk_irq(1'b1);
        wr(ADDR_MASK, 32'h00000000);
        chk_irq(1'b0);
        pulse(3, 2);
        rdc(ADDR_STATUS, 32'h00000001, "pending sticky");
        wr(ADDR_MASK, 32'h00000001);
        chk_irq(1'b1);
        wr(ADDR_STATUS, 32'h00000001);
        rdc(ADDR_STATUS, 32'h00000000, "status w1c");
        pulse(3, 2);
        wr(ADDR_CLEAR, $urandom());
        rdc(ADDR_STATUS, 32'h00000000, "clear write");
        chk_irq(1'b0);
        // free-running down wraps through the full range
        wr(ADDR_RELOAD, 32'h00000001);
        wr(ADDR_CLEAR, 32'h00000000);
        wr(ADDR_CTRL, cw(2'h3, 1'b0, 1'b1, 1'b0, 2'h0, 4'h0));
        pulse(3, 2);
        rdc(ADDR_COUNT, 32'hFFFFFFFF, "free down wrap");
        rdc(ADDR_STATUS, 32'h00000001, "free timeout");
        // periodic up reloads at terminal count
        wr(ADDR_RELOAD, 32'hFFFFFFFD);
        wr(ADDR_CLEAR, 32'h00000000);
        wr(ADDR_CTRL, cw(2'h3, 1'b1, 1'b1, 1'b1, 2'h0, 4'h0));
        pulse(3, 3);
        rdc(ADDR_COUNT, 32'hFFFFFFFD, "overflow reload");
        // free-running up wraps to zero
        wr(ADDR_RELOAD, 32'hFFFFFFFE);
        wr(ADDR_CLEAR, 32'h00000000);
        wr(ADDR_CTRL, cw(2'h3, 1'b1, 1'b1, 1'b0, 2'h0, 4'h0));
        pulse(3, 2);
        rdc(ADDR_COUNT, 32'h00000000, "free up wrap");
        // time formats on the 32 kHz source at divide by 256
        for (int f = 2; f < 4; f++) begin
            wr(ADDR_RELOAD, 32'h00000000);
            wr(ADDR_CLEAR, 32'h00000000);
            wr(ADDR_CTRL, cw(2'h0, 1'b0, 1'b1, 1'b0,
                             2'(f), 4'h8));
            pulse(0, 256);
            wr(ADDR_CTRL, 32'h00000000);
            rdc(ADDR_COUNT, {(f == 2) ? 8'h17 : 8'hFF, 24'h3B3B63},
                "time wrap");
        end
        wr(ADDR_RELOAD, 32'h00003B63);
        wr(ADDR_CLEAR, 32'h00000000);
        wr(ADDR_CTRL, cw(2'h0, 1'b1, 1'b1, 1'b0, 2'h2, 4'h8));
        pulse(0, 256);
        rdc(ADDR_COUNT, 32'h00010000, "time carry");
        report_and_stop();
    end
endmodule // wut_top_bench
